// >>> inc/pcs_defs.vh
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

// ----------------------------------------
// counter and stack geometry
// ----------------------------------------
`define PCS_PC_WIDTH 13
`define PCS_LOW_WIDTH 8
`define PCS_HIGH_WIDTH 5
`define PCS_TARGET_WIDTH 11
`define PCS_STACK_DEPTH 8
`define PCS_PTR_WIDTH 3

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCS_LATCH_PAGE_HI 4
`define PCS_LATCH_PAGE_LO 3
`define PCS_PC_PAGE_HI 12
`define PCS_PC_PAGE_LO 11

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCS_PC_RESET 13'h0000
`define PCS_PTR_RESET 3'h0
`define PCS_ENTRY_RESET 13'h0000
`define PCS_LOW_RESET 8'h00

// ----------------------------------------
// interrupt vector address
// ----------------------------------------
`define PCS_VECTOR_ADDR 13'h0004

`endif

// >>> rtl/pcs_counter.v
`timescale 1ns/1ps
`include "pcs_defs.vh"

// Function
// - a 13-bit counter addresses the next fetch and its low byte reads and writes.
// - the upper five bits have no direct write path of their own and are not exposed.
// - reset clears the whole counter to zero.
// - a low-byte write loads the upper five bits from the latch in the same step.
// - call and jump take 11 bits from the instruction and bits 12:11 from latch bits 4:3.
// - call and interrupt vectoring push the full 13-bit return address.
// - any return pops the top entry into the whole counter.
// - pushes and pops leave the latch untouched.
// - the stack is 8 entries of 13 bits with a hidden pointer.
// - the stack is circular, the ninth push overwriting the first.
// - no overflow or underflow indication exists.
module pcs_counter #(
    parameter PC_W = `PCS_PC_WIDTH,
    parameter DEPTH = `PCS_STACK_DEPTH,
    parameter [PC_W-1:0] VECTOR_ADDR = `PCS_VECTOR_ADDR
) (
    input wire ref_clk_in, // core clock
    input wire rst_n_in, // sync reset, active low
    input wire step_in, // one instruction completes
    input wire low_write_in, // result goes to counter_low_byte
    input wire [7:0] low_data_in, // value written to low byte
    input wire [4:0] upper_address_latch_in, // latch contents, owned by core
    input wire jump_op_in, // jump instruction
    input wire call_op_in, // call instruction
    input wire [10:0] target_in, // instruction-word target bits
    input wire return_op_in, // plain return
    input wire return_with_literal_op_in, // return with literal
    input wire interrupt_return_op_in, // return from interrupt
    input wire irq_vector_in, // interrupt vectoring
    output reg [PC_W-1:0] pc_out, // fetch address
    output reg [7:0] counter_low_byte_out // readable low byte
);

    reg [PC_W-1:0] pc_q;
    reg [PC_W-1:0] pc_d;
    reg push;
    reg pop;
    wire any_return;
    wire [PC_W-1:0] pc_inc;
    wire [PC_W-1:0] stack_top;

    assign any_return = return_op_in | return_with_literal_op_in | interrupt_return_op_in;
    assign pc_inc = pc_q + {{(PC_W-1){1'b0}}, 1'b1};

    // ----------------------------------------
    // next counter value, priority order
    // ----------------------------------------
    always @*
    begin
        pc_d = pc_q;
        push = 1'b0;
        pop = 1'b0;
        if (step_in)
        begin
            if (irq_vector_in)
            begin
                push = 1'b1;
                pc_d = VECTOR_ADDR;
            end
            else if (call_op_in)
            begin
                push = 1'b1;
                pc_d = {upper_address_latch_in[`PCS_LATCH_PAGE_HI:`PCS_LATCH_PAGE_LO], target_in};
            end
            else if (jump_op_in)
                pc_d = {upper_address_latch_in[`PCS_LATCH_PAGE_HI:`PCS_LATCH_PAGE_LO], target_in};
            else if (any_return)
            begin
                pop = 1'b1;
                pc_d = stack_top;
            end
            else if (low_write_in)
                pc_d = {upper_address_latch_in, low_data_in};
            else
                pc_d = pc_inc;
        end
    end

    // ----------------------------------------
    // counter register, outputs from flops
    // ----------------------------------------
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            pc_q <= `PCS_PC_RESET;
            pc_out <= `PCS_PC_RESET;
            counter_low_byte_out <= `PCS_LOW_RESET;
        end
        else
        begin
            pc_q <= pc_d;
            pc_out <= pc_d;
            counter_low_byte_out <= pc_d[7:0];
        end
    end

    // ----------------------------------------
    // return-address stack; latch is input only
    // ----------------------------------------
    pcs_stack #(
        .WIDTH(PC_W),
        .DEPTH(DEPTH),
        .PTR_W(`PCS_PTR_WIDTH)
    ) u_stack (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .push_in(push),
        .pop_in(pop),
        .push_data_in(irq_vector_in ? pc_q : pc_inc),
        .top_out(stack_top)
    );

endmodule // pcs_counter

// >>> rtl/pcs_stack.v
`timescale 1ns/1ps
`include "pcs_defs.vh"

// circular return-address stack, no overflow or underflow indication
module pcs_stack #(
    parameter WIDTH = `PCS_PC_WIDTH,
    parameter DEPTH = `PCS_STACK_DEPTH,
    parameter PTR_W = `PCS_PTR_WIDTH
) (
    input wire ref_clk_in, // core clock
    input wire rst_n_in, // sync reset, active low
    input wire push_in, // store push_data_in on top
    input wire pop_in, // remove top entry
    input wire [WIDTH-1:0] push_data_in, // return address to store
    output wire [WIDTH-1:0] top_out // current top entry
);

    reg [WIDTH-1:0] entry_q [0:DEPTH-1];
    reg [PTR_W-1:0] ptr_q; // next free slot, hidden from software
    wire [PTR_W-1:0] top_idx;

    assign top_idx = ptr_q - {{(PTR_W-1){1'b0}}, 1'b1};
    assign top_out = entry_q[top_idx];

    // ----------------------------------------
    // pointer wraps modulo depth
    // ----------------------------------------
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            ptr_q <= `PCS_PTR_RESET;
        else if (push_in)
            ptr_q <= ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
        else if (pop_in)
            ptr_q <= top_idx;
    end

    // ----------------------------------------
    // entries, one per slot
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1)
        begin : g_entry
            // slot index at pointer width, genvars take no part-select
            localparam [PTR_W-1:0] SLOT = gi;
            always @(posedge ref_clk_in)
            begin
                if (!rst_n_in)
                    entry_q[gi] <= `PCS_ENTRY_RESET;
                else if (push_in && ptr_q == SLOT)
                    entry_q[gi] <= push_data_in;
            end
        end
    endgenerate

endmodule // pcs_stack

// >>> tb/pcs_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// counter and stack sequencing checks
// ----------------------------------------
module pcs_checker (
    input wire ref_clk_in, rst_n_in, step_in, low_write_in, jump_op_in, call_op_in, irq_vector_in,
    input wire return_op_in, return_with_literal_op_in, interrupt_return_op_in,
    input wire [7:0] low_data_in, counter_low_byte_out,
    input wire [4:0] upper_address_latch_in,
    input wire [10:0] target_in,
    input wire [12:0] pc_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!rst_n_in);
// event groups: any return first, then the pushing events irq and call
wire rt = return_op_in | return_with_literal_op_in | interrupt_return_op_in;
wire up = irq_vector_in | call_op_in;
chk_reset_zero:
    assert property (disable iff (1'b0) !rst_n_in |=> pc_out == 13'h0000) else $error("pc not cleared");
chk_low_mirror:
    assert property (counter_low_byte_out == pc_out[7:0]) else $error("low byte differs");
chk_idle_hold:
    assert property (!step_in |=> $stable(pc_out)) else $error("pc moved without step");
chk_call_page:
    assert property (step_in && call_op_in && !irq_vector_in |=>
        pc_out == {$past(upper_address_latch_in[4:3]), $past(target_in)}) else $error("call target wrong");
chk_jump_page:
    assert property (step_in && jump_op_in && !up |=>
        pc_out == {$past(upper_address_latch_in[4:3]), $past(target_in)}) else $error("jump target wrong");
chk_low_load:
    assert property (step_in && low_write_in && !up && !jump_op_in && !rt |=>
        pc_out == {$past(upper_address_latch_in), $past(low_data_in)}) else $error("low write wrong");
chk_count_up:
    assert property (step_in && !(up | jump_op_in | rt | low_write_in) |=>
        pc_out == $past(pc_out) + 13'h1) else $error("increment wrong");
chk_call_ret:
    assert property (step_in && call_op_in && !irq_vector_in ##1 !step_in ##1 step_in && rt && !up &&
        !jump_op_in |=> pc_out == $past(pc_out, 3) + 13'h1) else $error("return address wrong");
endmodule // pcs_checker
bind pcs_counter pcs_checker i_chk (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .step_in(step_in),
    .low_write_in(low_write_in),
    .jump_op_in(jump_op_in),
    .call_op_in(call_op_in),
    .irq_vector_in(irq_vector_in),
    .return_op_in(return_op_in),
    .return_with_literal_op_in(return_with_literal_op_in),
    .interrupt_return_op_in(interrupt_return_op_in),
    .low_data_in(low_data_in),
    .counter_low_byte_out(counter_low_byte_out),
    .upper_address_latch_in(upper_address_latch_in),
    .target_in(target_in),
    .pc_out(pc_out)
);

// >>> tb/pcs_core_model.sv
`timescale 1ns/1ps
// core-side upper address latch, software owned
module pcs_core_model (
    input wire clk_in, // core clock
    input wire wr_in, // software move into latch
    input wire [4:0] wdata_in, // new latch value
    output reg [4:0] upper_address_latch_out // latch seen by block
);
initial upper_address_latch_out = 5'h00;
// page set before far branch, loaded from wdata_in on each wr_in
always @(posedge clk_in)
    if (wr_in) upper_address_latch_out <= wdata_in;
endmodule // pcs_core_model

// >>> tb/pcs_counter_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin failures = failures + 1; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module pcs_counter_tb_top;
reg clk = 0, rst_n = 0, st = 0, wr = 0;
reg [6:0] ev = 0; // irq call jump ret retlit iret lowwr
reg [7:0] ld = 0;
reg [4:0] wd = 0;
reg [10:0] tg = 0;
wire [4:0] lat;
wire [12:0] pc;
wire [7:0] lo;
integer failures = 0, tests_run = 0, cyc = 0, i;
reg [12:0] e [0:8];
reg [12:0] p;
initial forever #2.5 clk = ~clk;
pcs_core_model i_core (.clk_in(clk), .wr_in(wr), .wdata_in(wd), .upper_address_latch_out(lat));
pcs_counter i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .step_in(st), .low_write_in(ev[0]),
    .low_data_in(ld), .upper_address_latch_in(lat), .jump_op_in(ev[4]), .call_op_in(ev[5]),
    .target_in(tg), .return_op_in(ev[3]), .return_with_literal_op_in(ev[2]),
    .interrupt_return_op_in(ev[1]), .irq_vector_in(ev[6]), .pc_out(pc), .counter_low_byte_out(lo));
// one step with the given events
task go(input [6:0] k, input [10:0] t);
begin
    @(posedge clk); ev <= k; st <= 1; tg <= t;
    @(posedge clk); ev <= 0; st <= 0; #1;
end
endtask
task setlat(input [4:0] v);
begin
    @(posedge clk); wr <= 1; wd <= v;
    @(posedge clk); wr <= 0;
end
endtask
task tally_and_finish;
begin
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
end
endtask
// low write carries latch, then increment carries into upper bits
task t_low;
begin
    ld <= 8'hff; go(7'h01, 11'h000); `CHK(pc, 13'h00ff)
    go(7'h00, 11'h000); `CHK(pc, 13'h0100)
    setlat(5'h1f); ld <= 8'h3c; go(7'h01, 11'h000); `CHK(lo, 8'h3c)
    `CHK(pc, 13'h1f3c)
end
endtask
// jump page from latch bits, call wins over jump and low write
task t_page;
begin
    setlat(5'h17); go(7'h10, 11'h7ff); `CHK(pc, 13'h17ff)
    setlat(5'h08); go(7'h31, 11'h055); `CHK(pc, 13'h0855)
    go(7'h08, 11'h000); `CHK(pc, 13'h1800)
end
endtask
// nine calls wrap, every return kind pops
task t_stack;
begin
    for (i = 0; i < 9; i = i + 1) begin e[i] = pc + 13'h1; go(7'h20, {i[6:0], 4'h0}); end
    for (i = 8; i > 0; i = i - 1) begin go(7'h08 >> (i % 3), 11'h000); `CHK(pc, e[i]) end
    go(7'h08, 11'h000); `CHK(pc, e[8])
end
endtask
// interrupt pushes current pc, vector, then interrupt return
task t_irq;
begin
    p = pc; go(7'h7f, 11'h055); `CHK(pc, 13'h0004)
    go(7'h02, 11'h000); `CHK(pc, p)
end
endtask
// mid-run reset clears the counter
task t_reset;
begin
    @(posedge clk); rst_n <= 0;
    @(posedge clk); rst_n <= 1; #1; `CHK(pc, 13'h0000)
end
endtask
always @(posedge clk) begin cyc = cyc + 1; if (cyc == 2000) begin failures = failures + 1; tally_and_finish; end end
initial begin
    repeat (4) @(posedge clk); rst_n <= 1; #1; `CHK(pc, 13'h0000)
    t_low; t_page; t_stack; t_irq; t_reset;
    tally_and_finish;
end
endmodule // pcs_counter_tb_top
